//--- shared/aiu_regs.svh
/*
 Register offsets, field positions, reset values and timing figures of the
 auxiliary I/O handshake unit.
 Assumes a 200 MHz system clock and a 32-bit classic Wishbone register bus.
*/
`ifndef AIU_REGS_SVH
`define AIU_REGS_SVH


// ==========================================================================
// Register byte offsets
`define AIU_OFS_CTRL   6'h00
`define AIU_OFS_STAT   6'h04
`define AIU_OFS_PROG0  6'h08
`define AIU_OFS_PROG1  6'h0C
`define AIU_OFS_CFDAT  6'h10
`define AIU_OFS_CMD    6'h14

// ==========================================================================
// Control register fields
`define AIU_CTL_W      7
`define AIU_CTL_PROBE  0
`define AIU_CTL_AIR    1
`define AIU_CTL_FEED5  2
`define AIU_CTL_FEED6  3
`define AIU_CTL_FHOLD  4
`define AIU_CTL_FSHOLD 5
`define AIU_CTL_ESTOP  6
`define AIU_CTL_RST    7'h00

// Command register fields (write one to act)
`define AIU_CMD_POP    0
`define AIU_CMD_ERRSET 1
`define AIU_CMD_ERRCLR 2

// Status register fields
`define AIU_ST_V0      0
`define AIU_ST_V1      1
`define AIU_ST_EN      2
`define AIU_ST_PRDY    3
`define AIU_ST_PERM5   4
`define AIU_ST_PERM6   5
`define AIU_ST_CFBUSY  6
`define AIU_ST_AIRTO   7
`define AIU_ST_ERR     8

// ==========================================================================
// Input vector layout and widths
`define AIU_BCD_W      12
`define AIU_CFD_W      8
`define AIU_NIN        19
`define AIU_IN_CHG1    12
`define AIU_IN_CHG2    13
`define AIU_IN_EN      14
`define AIU_IN_PRDY    15
`define AIU_IN_MFRDY   16
`define AIU_IN_PERM5   17
`define AIU_IN_PERM6   18

// ==========================================================================
// Timing figures and the largest decimal digit
`define AIU_CLK_KHZ     200000
`define AIU_CF_SETUP_MS 50
`define AIU_CF_HOLD_MS  100
`define AIU_AIR_MAX_MS  3800
`define AIU_FILT_MS     1
`define AIU_BCD_MAX     4'h9

`endif

//--- shared/aiu_pkg.sv
/*
 Types shared by the auxiliary I/O handshake unit.
 Assumes nothing of its surroundings.
*/
`default_nettype none
package aiu_pkg;
   // Cutting-force strobe sequencer states
   typedef enum logic [1:0] {
      CF_IDLE  = 2'b00,
      CF_SETUP = 2'b01,
      CF_HIGH  = 2'b10,
      CF_REL   = 2'b11
   } aiu_cf_t;

   typedef logic [31:0] aiu_cnt_t;
endpackage : aiu_pkg
`default_nettype wire

//--- hdl/aiu_in_filter.sv
/*
 Two-stage synchroniser plus sampled glitch filter for the discrete inputs.
 Assumes a tick period of at least two clock cycles.
*/
`timescale 1ns/1ps
`default_nettype none
`include "aiu_regs.svh"
module aiu_in_filter (
   input  wire logic                   clk_sys,
   input  wire logic                   sys_rst,
   input  wire logic [`AIU_NIN-1:0]    rawIn,
   input  wire aiu_pkg::aiu_cnt_t      tickLen,
   output logic      [`AIU_NIN-1:0]    cleanOut
);
   import aiu_pkg::*;

   typedef struct packed {
      logic [`AIU_NIN-1:0] s1;
      logic [`AIU_NIN-1:0] s2;
      logic [`AIU_NIN-1:0] smp;
      logic [`AIU_NIN-1:0] cln;
      aiu_cnt_t            cnt;
   } aiu_filt_t;

   aiu_filt_t q;
   aiu_filt_t d;

   // A bit is accepted once two tick samples agree
   always_comb begin
      d = q;
      d.s1 = rawIn;
      d.s2 = q.s1;
      if (q.cnt >= tickLen - 32'h0000_0001) begin
         d.cnt = '0;
         d.smp = q.s2;
         for (int i = 0; i < `AIU_NIN; i++) begin
            if (q.s2[i] == q.smp[i]) begin
               d.cln[i] = q.s2[i];
            end
         end
      end else begin
         d.cnt = q.cnt + 32'h0000_0001;
      end
      if (sys_rst) begin
         d = '0;
      end
   end

   // State register
   always_ff @(posedge clk_sys) begin
      q <= d;
   end

   assign cleanOut = q.cln;
endmodule : aiu_in_filter
`default_nettype wire

//--- hdl/aiu_timer.sv
/*
 One-shot interval timer: expired rises limit+2 cycles after a start pulse.
 Assumes limit is held stable while the timer runs.
*/
`timescale 1ns/1ps
`default_nettype none
module aiu_timer (
   input  wire logic              clk_sys,
   input  wire logic              sys_rst,
   input  wire logic              start,
   input  wire logic              stop,
   input  wire aiu_pkg::aiu_cnt_t limit,
   output logic                   expired
);
   import aiu_pkg::*;

   typedef struct packed {
      aiu_cnt_t cnt;
      logic     run;
      logic     exp;
   } aiu_tmr_t;

   aiu_tmr_t q;
   aiu_tmr_t d;

   // Count while running; start restarts, stop abandons
   always_comb begin
      d = q;
      if (start) begin
         d.cnt = '0;
         d.run = 1'b1;
         d.exp = 1'b0;
      end else if (stop) begin
         d.run = 1'b0;
         d.exp = 1'b0;
      end else if (q.run) begin
         if (q.cnt == limit) begin
            d.run = 1'b0;
            d.exp = 1'b1;
         end else begin
            d.cnt = q.cnt + 32'h0000_0001;
         end
      end
      if (sys_rst) begin
         d = '0;
      end
   end

   // State register
   always_ff @(posedge clk_sys) begin
      q <= d;
   end

   assign expired = q.exp;
endmodule : aiu_timer
`default_nettype wire

//--- hdl/aiu_top.sv
/*
 Auxiliary I/O handshake unit: external program call buffers, cutting-force
 data strobe, axis 5/6 motion-expected, probe and air-blow outputs, error flag.
 Assumes a classic Wishbone master and a 200 MHz clock; discrete inputs arrive
 from the machine interface logic and are filtered here.
*/
`timescale 1ns/1ps
`default_nettype none
`include "aiu_regs.svh"
module aiu_top #(
   parameter int CF_SETUP_CYC = `AIU_CF_SETUP_MS * `AIU_CLK_KHZ,
   parameter int CF_HOLD_CYC  = `AIU_CF_HOLD_MS * `AIU_CLK_KHZ,
   parameter int AIR_MAX_CYC  = `AIU_AIR_MAX_MS * `AIU_CLK_KHZ,
   parameter int FILT_CYC     = `AIU_FILT_MS * `AIU_CLK_KHZ
) (
   input  wire logic                   clk_sys,
   input  wire logic                   sys_rst,
   input  wire logic                   wb_cyc_i,
   input  wire logic                   wb_stb_i,
   input  wire logic                   wb_we_i,
   input  wire logic [5:0]             wb_adr_i,
   input  wire logic [3:0]             wb_sel_i,
   input  wire logic [31:0]            wb_dat_i,
   output logic      [31:0]            wb_dat_o,
   output logic                        wb_ack_o,
   input  wire logic [`AIU_BCD_W-1:0]  bcdIn,
   input  wire logic                   chgFirst,
   input  wire logic                   chgSecond,
   input  wire logic                   callEnable,
   input  wire logic                   probeReady,
   input  wire logic                   mfReady,
   input  wire logic [1:0]             motionPerm,
   output logic                        progEmpty,
   output logic                        cfStrobe,
   output logic      [`AIU_CFD_W-1:0]  cfData,
   output logic      [1:0]             motionExp,
   output logic                        probeAct,
   output logic                        airBlow,
   output logic                        errFlag
);
   import aiu_pkg::*;

   // Timer limits: the timer adds two cycles of its own to each interval
   localparam aiu_cnt_t CF_SETUP_LIM = 32'(CF_SETUP_CYC - 2);
   localparam aiu_cnt_t CF_HOLD_LIM  = 32'(CF_HOLD_CYC - 2);
   localparam aiu_cnt_t AIR_LIM      = 32'(AIR_MAX_CYC - 2);
   localparam aiu_cnt_t FILT_LEN     = 32'(FILT_CYC);

   typedef struct packed {
      logic                   ack;
      logic [31:0]            dat;
      logic [`AIU_CTL_W-1:0]  ctl;
      logic [`AIU_CFD_W-1:0]  cfd;
      aiu_cf_t                cf;
      logic [`AIU_BCD_W-1:0]  b0;
      logic [`AIU_BCD_W-1:0]  b1;
      logic                   v0;
      logic                   v1;
      logic [1:0]             chgPrev;
      logic                   err;
      logic                   empty;
      logic                   strobe;
      logic [1:0]             mv;
      logic                   probe;
      logic                   air;
      logic                   airTo;
      aiu_cnt_t               hHigh;
      aiu_cnt_t               hAir;
   } aiu_main_t;

   aiu_main_t q;
   aiu_main_t d;

   // ========================================================================
   // Input conditioning and timers
   logic [`AIU_NIN-1:0] filt;
   logic                cfGo;
   logic                cfExp;
   logic                airGo;
   logic                airStop;
   logic                airExp;
   aiu_cnt_t            cfLim;

   aiu_in_filter u_filt (
      .clk_sys  (clk_sys),
      .sys_rst  (sys_rst),
      .rawIn    ({motionPerm, mfReady, probeReady, callEnable,
                  chgSecond, chgFirst, bcdIn}),
      .tickLen  (FILT_LEN),
      .cleanOut (filt)
   );

   // Setup interval until the strobe is up, hold interval while it stands
   assign cfLim = (q.cf == CF_HIGH) ? CF_HOLD_LIM : CF_SETUP_LIM;

   aiu_timer u_cf_tmr (
      .clk_sys (clk_sys),
      .sys_rst (sys_rst),
      .start   (cfGo),
      .stop    (1'b0),
      .limit   (cfLim),
      .expired (cfExp)
   );

   aiu_timer u_air_tmr (
      .clk_sys (clk_sys),
      .sys_rst (sys_rst),
      .start   (airGo),
      .stop    (airStop),
      .limit   (AIR_LIM),
      .expired (airExp)
   );

   // Non-decimal digit check over the three decades
   function automatic logic bcdBad(input logic [`AIU_BCD_W-1:0] v);
      logic bad;
      bad = 1'b0;
      for (int k = 0; k < 3; k++) begin
         if (v[4*k +: 4] > `AIU_BCD_MAX) begin
            bad = 1'b1;
         end
      end
      return bad;
   endfunction : bcdBad

   // ========================================================================
   // Next-state logic
   logic                  access;
   logic                  wr;
   logic                  pop;
   logic                  errSet;
   logic                  errClr;
   logic                  callEn;
   logic                  anyHold;
   logic [1:0]            rise;
   logic [`AIU_BCD_W-1:0] bcdF;

   always_comb begin
      d = q;
      access  = wb_cyc_i && wb_stb_i && !q.ack;
      wr      = wb_cyc_i && wb_stb_i && q.ack && wb_we_i && wb_sel_i[0]; // Lands as ack is seen
      pop     = wr && (wb_adr_i == `AIU_OFS_CMD) && wb_dat_i[`AIU_CMD_POP];
      errSet  = wr && (wb_adr_i == `AIU_OFS_CMD) && wb_dat_i[`AIU_CMD_ERRSET];
      errClr  = wr && (wb_adr_i == `AIU_OFS_CMD) && wb_dat_i[`AIU_CMD_ERRCLR];
      callEn  = filt[`AIU_IN_EN];
      bcdF    = filt[`AIU_BCD_W-1:0];
      rise    = filt[`AIU_IN_CHG2:`AIU_IN_CHG1] & ~q.chgPrev;
      cfGo    = 1'b0;
      airGo   = 1'b0;
      airStop = 1'b0;

      // Bus answer: one ack per request, unmapped reads give zero
      d.ack = access;
      if (access && !wb_we_i) begin
         case (wb_adr_i)
            `AIU_OFS_CTRL:  d.dat = 32'(q.ctl);
            `AIU_OFS_STAT:  d.dat = 32'({q.err, q.airTo, q.cf != CF_IDLE,
                                         filt[`AIU_IN_PERM6], filt[`AIU_IN_PERM5],
                                         filt[`AIU_IN_PRDY], callEn, q.v1, q.v0});
            `AIU_OFS_PROG0: d.dat = 32'(q.b0);
            `AIU_OFS_PROG1: d.dat = 32'(q.b1);
            `AIU_OFS_CFDAT: d.dat = 32'(q.cfd);
            default:        d.dat = 32'h0000_0000;
         endcase
      end
      if (wr && (wb_adr_i == `AIU_OFS_CTRL)) begin
         d.ctl = wb_dat_i[`AIU_CTL_W-1:0];
      end

      // Air-blow: time-limited; expiry clears the request and flags it
      if (d.ctl[`AIU_CTL_AIR] && !q.ctl[`AIU_CTL_AIR]) begin
         airGo = 1'b1;
      end else if (!d.ctl[`AIU_CTL_AIR] && q.ctl[`AIU_CTL_AIR]) begin
         airStop = 1'b1;
      end
      if (airExp && q.ctl[`AIU_CTL_AIR]) begin
         d.ctl[`AIU_CTL_AIR] = 1'b0;
         d.airTo = 1'b1;
         airStop = 1'b1;
      end else if (airGo) begin
         d.airTo = 1'b0;
      end
      d.air = d.ctl[`AIU_CTL_AIR];
      // Probe activation waits for the air blow to finish
      d.probe = q.ctl[`AIU_CTL_PROBE] && !q.air;

      // Motion expected follows the feed request unless any hold is active
      anyHold = q.ctl[`AIU_CTL_FHOLD] || q.ctl[`AIU_CTL_FSHOLD] ||
                q.ctl[`AIU_CTL_ESTOP];
      d.mv = {q.ctl[`AIU_CTL_FEED6], q.ctl[`AIU_CTL_FEED5]};
      if (anyHold) begin
         d.mv = 2'b00;
      end

      // Program number buffers: consume first, then capture wins
      d.chgPrev = filt[`AIU_IN_CHG2:`AIU_IN_CHG1];
      if (pop) begin
         if (q.v0) begin
            d.b0 = q.b1;
            d.v0 = q.v1;
            d.v1 = 1'b0;
         end else begin
            d.v1 = 1'b0;
         end
      end
      if (rise[0] && callEn) begin
         d.b0 = bcdF;
         d.v0 = 1'b1;
      end
      if (rise[1] && callEn) begin
         d.b1 = bcdF;
         d.v1 = 1'b1;
      end
      if (!callEn) begin
         d.v0 = 1'b0;
         d.v1 = 1'b0;
      end
      d.empty = callEn && !d.v0 && !d.v1;

      // Error flag: set on command or a non-decimal captured number
      if (errClr) begin
         d.err = 1'b0;
      end
      if (errSet || ((rise[0] || rise[1]) && callEn && bcdBad(bcdF))) begin
         d.err = 1'b1;
      end

      // Cutting-force data strobe sequencer
      case (q.cf)
         CF_IDLE: begin
            if (wr && (wb_adr_i == `AIU_OFS_CFDAT)) begin
               d.cfd = wb_dat_i[`AIU_CFD_W-1:0];
               d.cf  = CF_SETUP;
               cfGo  = 1'b1;
            end
         end
         CF_SETUP: begin
            if (cfExp) begin
               d.strobe = 1'b1;
               d.cf     = CF_HIGH;
               cfGo     = 1'b1;
            end
         end
         CF_HIGH: begin
            if (cfExp && filt[`AIU_IN_MFRDY]) begin
               d.strobe = 1'b0;
               d.cf     = CF_REL;
            end
         end
         CF_REL: begin
            // Data stays put, but the partner must no longer use it
            if (!filt[`AIU_IN_MFRDY]) begin
               d.cf = CF_IDLE;
            end
         end
         default: begin
            d.cf = CF_IDLE;
         end
      endcase

      // Helper counts of strobe and air-blow high time
      d.hHigh = q.strobe ? q.hHigh + 32'h0000_0001 : 32'h0000_0000;
      d.hAir  = q.air ? q.hAir + 32'h0000_0001 : 32'h0000_0000;

      if (sys_rst) begin
         d     = '0;
         d.ctl = `AIU_CTL_RST;
      end
   end

   // State register
   always_ff @(posedge clk_sys) begin
      q <= d;
   end

   // ========================================================================
   // Outputs, all straight from the state register
   assign wb_ack_o  = q.ack;
   assign wb_dat_o  = q.dat;
   assign progEmpty = q.empty;
   assign cfStrobe  = q.strobe;
   assign cfData    = q.cfd;
   assign motionExp = q.mv;
   assign probeAct  = q.probe;
   assign airBlow   = q.air;
   assign errFlag   = q.err;

   // ========================================================================
   // Assertions
   sequence sAckSeen;
      q.cf == CF_HIGH && cfExp && filt[`AIU_IN_MFRDY];
   endsequence

   sequence sSetupDone;
      q.cf == CF_SETUP && cfExp;
   endsequence

   AST_EMPTY_HIGH: assert property (@(posedge clk_sys) disable iff (sys_rst)
      progEmpty |-> !q.v0 && !q.v1 && $past(filt[`AIU_IN_EN]))
      else $error("empty output high with a buffer full or enable low");

   AST_FILL_LOW: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (q.v0 || q.v1) |-> !progEmpty)
      else $error("empty output high while a buffer holds a number");

   AST_POP_EMPTY: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (pop && q.v0 && !q.v1 && rise == 2'b00 && filt[`AIU_IN_EN]) |=> progEmpty)
      else $error("empty output did not rise after consuming the buffer");

   AST_ENABLE_CLEAR: assert property (@(posedge clk_sys) disable iff (sys_rst)
      !filt[`AIU_IN_EN] |=> !q.v0 && !q.v1 && !progEmpty)
      else $error("buffers not cleared by enable low");

   AST_CF_RISE: assert property (@(posedge clk_sys) disable iff (sys_rst)
      $rose(cfStrobe) |-> $past(q.cf == CF_SETUP && cfExp))
      else $error("strobe rose without the setup interval elapsing");

   AST_CF_SETUP_NEXT: assert property (@(posedge clk_sys) disable iff (sys_rst)
      sSetupDone |=> cfStrobe ##1 cfStrobe)
      else $error("strobe not raised after setup interval");

   AST_CF_DROP: assert property (@(posedge clk_sys) disable iff (sys_rst)
      sAckSeen |=> !cfStrobe && q.cf == CF_REL)
      else $error("strobe not dropped after acknowledge");

   AST_CF_MIN: assert property (@(posedge clk_sys) disable iff (sys_rst)
      $fell(cfStrobe) |-> q.hHigh >= 32'(CF_HOLD_CYC))
      else $error("strobe high shorter than the minimum");

   AST_MOVE_SET: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (q.ctl[`AIU_CTL_FEED5] && !anyHold) |=> motionExp[0])
      else $error("motion expected axis 5 missing on feed request");

   AST_MOVE_HOLD: assert property (@(posedge clk_sys) disable iff (sys_rst)
      anyHold |=> motionExp == 2'b00)
      else $error("motion expected active during a hold");

   AST_PROBE: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (q.ctl[`AIU_CTL_PROBE] && !q.air) |=> probeAct)
      else $error("probe activation not driven");

   AST_AIR_MAX: assert property (@(posedge clk_sys) disable iff (sys_rst)
      q.hAir <= 32'(AIR_MAX_CYC))
      else $error("air blow exceeded its longest time");

   AST_ERR_HOLD: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (errFlag && !errClr) |=> errFlag)
      else $error("error flag dropped without a reset");

endmodule : aiu_top
`default_nettype wire

//--- test/aiu_partner.sv
/*
 Machine interface model at the discrete pins of the unit.
 Assumes the bench sets callEnable and ackDly and calls send.
*/
`timescale 1ns/1ps
`default_nettype none
module aiu_partner (
   input  wire logic       clk_sys,
   input  wire logic       cfStrobe,
   input  wire logic [1:0] motionExp,
   input  wire logic       probeAct,
   output logic     [11:0] bcdIn,
   output logic            chgFirst,
   output logic            chgSecond,
   output logic            callEnable,
   output logic            probeReady,
   output logic            mfReady,
   output logic     [1:0]  motionPerm
);
   int ackDly = 2;
   int ackCnt = 0;
   // ==========================================
   // Quiet levels at time zero
   initial begin
      {bcdIn, chgFirst, chgSecond, callEnable} = 15'h0000;
      {probeReady, mfReady, motionPerm} = 4'h0;
   end
   // Answers: permission, probe state, acknowledge held until strobe falls
   always @(posedge clk_sys) begin
      motionPerm <= motionExp;
      probeReady <= probeAct;
      ackCnt <= cfStrobe ? ackCnt + 1 : 0;
      mfReady <= cfStrobe && ackCnt >= ackDly;
   end
   // Program number transfer: data first, then a long strobe
   task send(input logic second, input logic [11:0] v);
      @(posedge clk_sys);
      bcdIn <= v;
      repeat (20) @(posedge clk_sys);
      chgFirst <= !second;
      chgSecond <= second;
      repeat (20) @(posedge clk_sys);
      {chgFirst, chgSecond} <= 2'h0;
      repeat (20) @(posedge clk_sys);
      bcdIn <= ~v; // Released lines show no stale value
   endtask : send
endmodule : aiu_partner
`default_nettype wire

//--- test/tb_auxiliary_io_handshake_unit.sv
/*
 Self-checking bench of the auxiliary I/O handshake unit.
 Assumes aiu_partner at the discrete pins; timing parameters are shortened.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_auxiliary_io_handshake_unit;
   import aiu_pkg::*;
   localparam int HOLD = 40;
   localparam int AIR  = 60;
   localparam int SETL = 20; // Filtered input settle time
   logic        clk_sys, sys_rst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
   logic        progEmpty, cfStrobe, probeAct, airBlow, errFlag, lastStb;
   logic        chgFirst, chgSecond, callEnable, probeReady, mfReady;
   logic [5:0]  wb_adr_i;
   logic [3:0]  wb_sel_i;
   logic [31:0] wb_dat_i, wb_dat_o, q;
   logic [11:0] bcdIn;
   logic [7:0]  cfData, lastDat;
   logic [1:0]  motionExp, motionPerm;
   int          bad_count, checked, tc, tDat, tRise, tFall, airRun, airLen, n;
   // ==========================================
   // Unit and its far side
   aiu_top #(.CF_SETUP_CYC(20), .CF_HOLD_CYC(HOLD), .AIR_MAX_CYC(AIR), .FILT_CYC(4)) i_dut (
      .clk_sys, .sys_rst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
      .wb_dat_i, .wb_dat_o, .wb_ack_o, .bcdIn, .chgFirst, .chgSecond, .callEnable,
      .probeReady, .mfReady, .motionPerm, .progEmpty, .cfStrobe, .cfData,
      .motionExp, .probeAct, .airBlow, .errFlag);
   aiu_partner i_par (
      .clk_sys, .cfStrobe, .motionExp, .probeAct, .bcdIn, .chgFirst, .chgSecond,
      .callEnable, .probeReady, .mfReady, .motionPerm);
   // Clock, 5 ns period
   initial begin
      clk_sys = 1'b0;
      forever #2.5 clk_sys = ~clk_sys;
   end
   // Times of data change and strobe edges, length of air blow
   always @(posedge clk_sys) begin
      tc <= tc + 1;
      lastDat <= cfData;
      lastStb <= cfStrobe;
      if (cfData !== lastDat) tDat <= tc;
      if (cfStrobe && !lastStb) tRise <= tc;
      if (!cfStrobe && lastStb) tFall <= tc;
      airRun <= airBlow ? airRun + 1 : 0;
      if (airBlow) airLen <= airRun + 1;
   end
   // ==========================================
   // Shared tasks
   task check(input string name, input logic [31:0] seen, want);
      checked++;
      if (seen !== want) begin
         bad_count++;
         $display("CHECK FAILED %s expected %h seen %h", name, want, seen);
      end
   endtask : check
   task complete_run();
      $display("checked %0d mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : complete_run
   task tmo(input int lim);
      if (n == lim) begin
         bad_count++;
         complete_run();
      end
   endtask : tmo
   task w(input int c);
      repeat (c) @(posedge clk_sys);
   endtask : w
   // Classic single cycle: all held until ack is sampled high
   task wb(input logic we, input logic [5:0] adr, input logic [7:0] d);
      @(posedge clk_sys);
      {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i} <= {2'h3, we, adr};
      wb_dat_i <= {24'h00_0000, d};
      for (n = 0; n < 20; n++) begin
         @(posedge clk_sys);
         if (wb_ack_o === 1'b1) break;
      end
      q = wb_dat_o;
      {wb_cyc_i, wb_stb_i} <= 2'h0;
      tmo(20);
   endtask : wb
   // ==========================================
   // Program call buffers: glitch, fill, consume, clear
   task t_call();
      i_par.callEnable <= 1'b1;
      w(SETL);
      check("empty", progEmpty, 1);
      i_par.chgFirst <= 1'b1;
      w(1);
      i_par.chgFirst <= 1'b0;
      w(SETL);
      wb(0, 6'h04, 0);
      check("glitch", q, 12'h004);
      i_par.send(0, 12'h235);
      check("empty", progEmpty, 0);
      i_par.send(1, 12'h255);
      wb(0, 6'h08, 0);
      check("prog0", q, 12'h235);
      wb(0, 6'h0C, 0);
      check("prog1", q, 12'h255);
      wb(1, 6'h14, 1);
      wb(0, 6'h08, 0);
      check("moved", q, 12'h255);
      check("empty", progEmpty, 0);
      wb(1, 6'h14, 1);
      w(2);
      check("empty", progEmpty, 1);
      i_par.send(0, 12'h001);
      i_par.callEnable <= 1'b0;
      w(SETL);
      wb(0, 6'h04, 0);
      check("cleared", q, 0);
      check("empty", progEmpty, 0);
      $display("t_call done");
   endtask : t_call
   // Error flag: bad digit, software set, set over clear
   task t_err();
      i_par.callEnable <= 1'b1;
      i_par.send(0, 12'h0A0);
      check("err", errFlag, 1);
      wb(1, 6'h14, 4);
      w(2);
      check("err", errFlag, 0);
      wb(1, 6'h14, 6);
      w(2);
      check("err", errFlag, 1);
      wb(1, 6'h14, 4);
      i_par.callEnable <= 1'b0;
      $display("t_err done");
   endtask : t_err
   // Cutting-force strobe with a prompt or a late acknowledge
   task t_cf(input int dly, input logic [7:0] v);
      int t0;
      t0 = tc;
      i_par.ackDly = dly;
      wb(1, 6'h10, v);
      wb(1, 6'h10, 8'h11);
      for (n = 0; n < 400 && !(tFall > t0 && mfReady === 1'b0); n++)
         @(posedge clk_sys);
      tmo(400);
      check("setup", tRise - tDat, 20);
      check("hold", tFall - tRise >= HOLD, 1);
      check("ackfirst", tFall - tRise > dly, 1);
      check("release", tFall - tRise <= ((dly > HOLD) ? dly : HOLD) + SETL, 1);
      check("data", cfData, v);
      wb(0, 6'h10, 0);
      check("cfread", q, v);
      w(SETL);
      wb(0, 6'h04, 0);
      check("idle", q[6], 0);
      $display("t_cf done");
   endtask : t_cf
   // Motion expected per axis and the three holds
   task t_motion();
      wb(1, 6'h00, 8'h0C);
      w(3);
      check("motion", motionExp, 2'h3);
      w(SETL);
      wb(0, 6'h04, 0);
      check("perm", q[5:4], 2'h3);
      for (int b = 4; b < 7; b++) begin
         wb(1, 6'h00, 8'h0C | (8'h01 << b));
         w(3);
         check("hold", motionExp, 2'h0);
      end
      wb(1, 6'h00, 8'h08);
      w(3);
      check("axis6", motionExp, 2'h2);
      $display("t_motion done");
   endtask : t_motion
   // Air blow first, bounded in length, then probe activation
   task t_air();
      wb(1, 6'h00, 8'h03);
      w(3);
      check("air", airBlow, 1);
      check("probe", probeAct, 0);
      for (n = 0; n < 200 && airBlow !== 1'b0; n++)
         @(posedge clk_sys);
      tmo(200);
      check("airlen", airLen, AIR);
      w(3);
      check("probe", probeAct, 1);
      wb(0, 6'h00, 0);
      check("ctrl", q, 12'h001);
      w(SETL);
      wb(0, 6'h04, 0);
      check("airto", q[7], 1);
      check("ready", q[3], 1);
      wb(1, 6'h00, 0);
      $display("t_air done");
   endtask : t_air
   // ==========================================
   // Reset, then the scenarios in turn
   initial begin
      {sys_rst, wb_cyc_i, wb_stb_i, wb_we_i} = 4'h8;
      wb_adr_i = 6'h00;
      wb_sel_i = 4'hF;
      wb_dat_i = 32'h0000_0000;
      w(10);
      sys_rst <= 1'b0;
      w(1);
      check("empty", progEmpty, 0);
      wb(1, 6'h3C, 8'hFF);
      wb(0, 6'h3C, 0);
      check("unmapped", q, 0);
      t_call();
      t_err();
      t_cf(2, 8'hA5);
      t_cf(70, 8'h5A);
      t_motion();
      t_air();
      complete_run();
   end
endmodule : tb_auxiliary_io_handshake_unit
`default_nettype wire
